// ### pscu_pair_matrix.sv
// All-pairs element comparator: 16 x 16 equal and order relations.
// Assumes word mode only reads entries with both indices below 8.
module pscu_pair_matrix
  import pscu_pkg::*;
(
  // Operands and format
  input  wire logic [VEC_W-1:0] src_a,
  input  wire logic [VEC_W-1:0] src_b,
  input  wire logic             word_mode,
  input  wire logic             signed_mode,
  // Relations, index a_elem*16 + b_elem
  output logic [255:0]          eq,
  output logic [255:0]          a_le_b,
  output logic [255:0]          b_le_a
);

  logic signed [16:0] ea [BYTE_N];
  logic signed [16:0] eb [BYTE_N];

  // One 17-bit signed form covers all four element formats
  function automatic logic signed [16:0] elem(input logic [VEC_W-1:0] x,
                                              input logic [3:0] k,
                                              input logic w,
                                              input logic s);
    logic [15:0] v;
    v = w ? x[16*k[2:0] +: 16] : {8'h00, x[8*k +: 8]};
    if (!s)
      elem = {1'b0, v};
    else if (w)
      elem = {v[15], v};
    else
      elem = {{9{v[7]}}, v[7:0]};
  endfunction : elem

  for (genvar g = 0; g < BYTE_N; g++) begin : g_elem
    assign ea[g] = elem(src_a, 4'(g), word_mode, signed_mode); // RULE2
    assign eb[g] = elem(src_b, 4'(g), word_mode, signed_mode); // RULE2
    for (genvar h = 0; h < BYTE_N; h++) begin : g_pair
      assign eq[g*16+h]     = ea[g] == eb[h]; // RULE4
      assign a_le_b[g*16+h] = ea[g] <= eb[h]; // RULE4
      assign b_le_a[g*16+h] = eb[h] <= ea[g]; // RULE4
    end
  end

endmodule : pscu_pair_matrix

// ### pscu_pkg.sv
// Constants, control immediate layout and operation codes for the packed
// string compare unit.
// Assumes the issue logic decodes the instruction into one operation code.
package pscu_pkg;

  localparam int VEC_W  = 128;
  localparam int BYTE_N = 16;
  localparam int WORD_N = 8;
  localparam int LEN_W  = 32;
  localparam int LANE_W = 64;
  localparam int LANE_N = 2;

  // Control immediate fields
  localparam int IMM_WORD_BIT = 0;
  localparam int IMM_SIGN_BIT = 1;
  localparam int IMM_AGG_LO   = 2;
  localparam int IMM_POL_LO   = 4;
  localparam int IMM_SEL_BIT  = 6;

  // Aggregation modes
  localparam logic [1:0] AGG_EQUAL_ANY     = 2'h0;
  localparam logic [1:0] AGG_RANGES        = 2'h1;
  localparam logic [1:0] AGG_EQUAL_EACH    = 2'h2;
  localparam logic [1:0] AGG_EQUAL_ORDERED = 2'h3;

  // Polarity bits: bit 0 negates, bit 1 limits negation to valid elements
  localparam int POL_NEG_BIT  = 0;
  localparam int POL_MASK_BIT = 1;

  // Legacy 128-bit alignment: low address bits that must be zero
  localparam logic [3:0] QALIGN_MASK = 4'hF;

  localparam logic [4:0] ELEM_N_BYTE = 5'h10;
  localparam logic [4:0] ELEM_N_WORD = 5'h08;
  localparam logic [15:0] VALID_MASK_BYTE = 16'hFFFF;
  localparam logic [15:0] VALID_MASK_WORD = 16'h00FF;

  typedef enum logic [2:0] {
    OP_EXPLICIT_LEN_COMPARE_INDEX = 3'h0,
    OP_EXPLICIT_LEN_COMPARE_MASK  = 3'h1,
    OP_NULL_TERM_COMPARE_MASK     = 3'h3,
    OP_NULL_TERM_COMPARE_INDEX    = 3'h2,
    OP_QUADWORD_GREATER_COMPARE   = 3'h6
  } pscu_op_e;

endpackage : pscu_pkg

// ### pscu_regfile_model.sv
// Register file side of the compare unit: keeps the last written results.
// Assumes write enables are one-cycle pulses sampled on the rising edge.
module pscu_regfile_model
  import pscu_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Writes from the unit
  input  wire logic             cnt_we,
  input  wire logic [LEN_W-1:0] cnt_d,
  input  wire logic             v0_we,
  input  wire logic [VEC_W-1:0] v0_d,
  // Architected state
  output logic      [LEN_W-1:0] cnt_q,
  output logic      [VEC_W-1:0] v0_q
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (cnt_we) cnt_q <= cnt_d;
    if (v0_we) v0_q <= v0_d;
  end
endmodule : pscu_regfile_model

// ### pscu_top.sv
// Packed string compare unit with quadword greater-than compare.
// Assumes the issue logic presents fully read operands, memory data already
// fetched, and accepts one result per cycle; results appear one cycle later.
// Function
// RULE1: Each source is 128 bits of sixteen bytes or eight words.
// RULE2: Elements are bytes or words, signed or unsigned, per the immediate.
// RULE3: Four compare types are selectable by the immediate.
// RULE4: All element pairs, up to 256, are compared in one operation.
// RULE5: Pair results are aggregated and then post-processed by polarity.
// RULE6: The 8-bit immediate picks format, mode, processing and output.
// RULE7: Index results go to the count register, masks to vector register 0.
// RULE8: The index reports the lowest or the highest set position.
// RULE9: Masks come as one bit per element or expanded to element width.
// RULE10: Explicit-length forms take one length register per operand.
// RULE11: Implicit-length elements are valid only below the first null.
// RULE12: Operands shorter than 16 bytes are handled as partial strings.
// RULE13: Source one is a vector register, source two register or memory.
// RULE14: These compares never fault on alignment; others keep their rule.
// RULE15: A companion op compares two signed quadword lanes for greater.
// RULE16: Software checks the feature flag at bit 20 before issuing.
// RULE17: Lengths beyond the element count cover all; nulls are all zero.
module pscu_top
  import pscu_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Request from issue
  input  wire logic             op_valid,
  input  wire pscu_op_e         op_kind,
  input  wire logic [7:0]       imm,
  input  wire logic [VEC_W-1:0] src_a,
  input  wire logic [VEC_W-1:0] src_b,
  input  wire logic             src_b_is_mem,
  input  wire logic [3:0]       mem_addr_lo,
  input  wire logic [LEN_W-1:0] first_length_gpr,
  input  wire logic [LEN_W-1:0] second_length_gpr,
  // Results to register file
  output logic                  res_valid,
  output logic                  count_gpr_we,
  output logic [LEN_W-1:0]      count_gpr,
  output logic                  vector_reg_zero_we,
  output logic [VEC_W-1:0]      vector_reg_zero,
  output logic                  dest_we,
  output logic [VEC_W-1:0]      dest,
  output logic                  align_fault
);

  logic [255:0]      eq;
  logic [255:0]      a_le_b;
  logic [255:0]      b_le_a;
  logic              word_mode;
  logic [1:0]        agg;
  logic [1:0]        pol;
  logic              sel;
  logic              explicit_len;
  logic              is_index;
  logic              is_qgt;
  logic [4:0]        n;
  logic [15:0]       nmask;
  logic [LEN_W-1:0]  mag_a;
  logic [LEN_W-1:0]  mag_b;
  logic [4:0]        lim_a;
  logic [4:0]        lim_b;
  logic [15:0]       va;
  logic [15:0]       vb;
  logic [15:0]       res1;
  logic [15:0]       res2;
  logic [4:0]        next_index;
  logic [VEC_W-1:0]  next_mask;
  logic [VEC_W-1:0]  next_qgt;
  logic              next_fault;

  // Decode of operation and immediate
  assign word_mode    = imm[IMM_WORD_BIT]; // RULE6 RULE1
  assign agg          = imm[IMM_AGG_LO +: 2]; // RULE6 RULE3
  assign pol          = imm[IMM_POL_LO +: 2]; // RULE6
  assign sel          = imm[IMM_SEL_BIT]; // RULE6
  assign explicit_len = op_kind == OP_EXPLICIT_LEN_COMPARE_INDEX ||
                        op_kind == OP_EXPLICIT_LEN_COMPARE_MASK;
  assign is_index     = op_kind == OP_EXPLICIT_LEN_COMPARE_INDEX ||
                        op_kind == OP_NULL_TERM_COMPARE_INDEX;
  assign is_qgt       = op_kind == OP_QUADWORD_GREATER_COMPARE;
  assign n            = word_mode ? ELEM_N_WORD : ELEM_N_BYTE; // RULE1
  assign nmask        = word_mode ? VALID_MASK_WORD : VALID_MASK_BYTE;

  // src_b may come from memory; data is the same either way
  pscu_pair_matrix u_matrix (
    .src_a       (src_a), // RULE13
    .src_b       (src_b),
    .word_mode   (word_mode),
    .signed_mode (imm[IMM_SIGN_BIT]),
    .eq          (eq),
    .a_le_b      (a_le_b),
    .b_le_a      (b_le_a)
  );

  // Negative lengths count by magnitude
  assign mag_a = first_length_gpr[LEN_W-1] ? LEN_W'(-first_length_gpr)
                                           : first_length_gpr;
  assign mag_b = second_length_gpr[LEN_W-1] ? LEN_W'(-second_length_gpr)
                                            : second_length_gpr;
  assign lim_a = (mag_a >= LEN_W'(n)) ? n : mag_a[4:0]; // RULE17 RULE10
  assign lim_b = (mag_b >= LEN_W'(n)) ? n : mag_b[4:0]; // RULE17 RULE10

  // Element validity
  always_comb begin
    logic seen_a;
    logic seen_b;
    logic nul_a;
    logic nul_b;
    nul_a = 1'b0;
    nul_b = 1'b0;
    seen_a = 1'b0;
    seen_b = 1'b0;
    va = '0;
    vb = '0;
    for (int i = 0; i < BYTE_N; i++) begin
      nul_a = word_mode ? (src_a[16*(i%8) +: 16] == 16'h0000)
                        : (src_a[8*i +: 8] == 8'h00); // RULE17
      nul_b = word_mode ? (src_b[16*(i%8) +: 16] == 16'h0000)
                        : (src_b[8*i +: 8] == 8'h00); // RULE17
      if (i < int'(n)) begin
        seen_a = seen_a | nul_a;
        seen_b = seen_b | nul_b;
        if (explicit_len) begin
          va[i] = i < int'(lim_a); // RULE10 RULE12
          vb[i] = i < int'(lim_b); // RULE10 RULE12
        end else begin
          va[i] = !seen_a; // RULE11 RULE12
          vb[i] = !seen_b; // RULE11 RULE12
        end
      end
    end
  end

  // Aggregation of pair results
  always_comb begin
    logic acc;
    acc = 1'b0;
    res1 = '0;
    for (int j = 0; j < BYTE_N; j++) begin
      acc = 1'b0;
      unique case (agg) // RULE3 RULE5
        AGG_EQUAL_ANY: begin
          for (int i = 0; i < BYTE_N; i++)
            acc = acc | (va[i] & vb[j] & eq[i*16+j]);
        end
        AGG_RANGES: begin
          for (int k = 0; k < BYTE_N-1; k += 2)
            acc = acc | (va[k] & va[k+1] & vb[j] &
                         a_le_b[k*16+j] & b_le_a[(k+1)*16+j]);
        end
        AGG_EQUAL_EACH: begin
          if (!va[j] && !vb[j])
            acc = 1'b1;
          else
            acc = va[j] & vb[j] & eq[j*17];
        end
        AGG_EQUAL_ORDERED: begin
          acc = 1'b1;
          for (int k = 0; k < BYTE_N; k++)
            if (j + k < int'(n) && va[k])
              acc = acc & vb[j+k] & eq[k*16+j+k];
        end
      endcase
      res1[j] = acc & (j < int'(n));
    end
  end

  // Polarity: masked negation leaves invalid second-operand positions alone
  always_comb begin
    if (!pol[POL_NEG_BIT])
      res2 = res1; // RULE5
    else if (pol[POL_MASK_BIT])
      res2 = (res1 ^ vb) & nmask; // RULE5
    else
      res2 = ~res1 & nmask; // RULE5
  end

  // Index, mask and quadword results
  always_comb begin
    next_index = n;
    next_mask = '0;
    next_qgt = '0;
    if (sel) begin
      for (int i = 0; i < BYTE_N; i++)
        if (res2[i])
          next_index = 5'(i); // RULE8
    end else begin
      for (int i = BYTE_N-1; i >= 0; i--)
        if (res2[i])
          next_index = 5'(i); // RULE8
    end
    if (!sel)
      next_mask[15:0] = res2; // RULE9
    else
      for (int i = 0; i < BYTE_N; i++)
        if (word_mode && i < WORD_N)
          next_mask[16*i +: 16] = {16{res2[i]}}; // RULE9
        else if (!word_mode)
          next_mask[8*i +: 8] = {8{res2[i]}}; // RULE9
    for (int l = 0; l < LANE_N; l++)
      next_qgt[LANE_W*l +: LANE_W] = {LANE_W{
        $signed(src_a[LANE_W*l +: LANE_W]) >
        $signed(src_b[LANE_W*l +: LANE_W])}}; // RULE15
  end

  // Only the legacy-aligned quadword op checks its memory address
  assign next_fault = op_valid && is_qgt && src_b_is_mem &&
                      (mem_addr_lo & QALIGN_MASK) != 4'h0; // RULE14

  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid          <= 1'b0;
      count_gpr_we       <= 1'b0;
      vector_reg_zero_we <= 1'b0;
      dest_we            <= 1'b0;
      align_fault        <= 1'b0;
    end else begin
      res_valid          <= op_valid;
      count_gpr_we       <= op_valid && !is_qgt && is_index; // RULE7
      vector_reg_zero_we <= op_valid && !is_qgt && !is_index; // RULE7
      dest_we            <= op_valid && is_qgt && !next_fault;
      align_fault        <= next_fault;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_gpr       <= '0;
      vector_reg_zero <= '0;
      dest            <= '0;
    end else if (op_valid) begin
      count_gpr       <= LEN_W'(next_index); // RULE7
      vector_reg_zero <= next_mask; // RULE7
      dest            <= next_qgt;
    end
  end

  a_result_latency: assert property (@(posedge clk) disable iff (rst)
    op_valid |=> res_valid) // RULE4
    else $error("result not one cycle after request");
  a_index_dest: assert property (@(posedge clk) disable iff (rst)
    op_valid && is_index |=> count_gpr_we && !vector_reg_zero_we) // RULE7
    else $error("index result went to the wrong register");
  a_mask_dest: assert property (@(posedge clk) disable iff (rst)
    op_valid && !is_index && !is_qgt |=> vector_reg_zero_we
    && !count_gpr_we) // RULE7
    else $error("mask result went to the wrong register");
  a_index_bound: assert property (@(posedge clk) disable iff (rst)
    op_valid && is_index |=> count_gpr <= LEN_W'($past(n))) // RULE8
    else $error("index beyond element count");
  a_word_index: assert property (@(posedge clk) disable iff (rst)
    op_valid && is_index && word_mode |=> count_gpr <= 32'h8) // RULE1
    else $error("word index beyond eight");
  a_bitmask_high: assert property (@(posedge clk) disable iff (rst)
    op_valid && !is_index && !is_qgt && !sel
    |=> vector_reg_zero[VEC_W-1:16] == '0) // RULE9
    else $error("bit mask has bits above element count");
  a_no_str_fault: assert property (@(posedge clk) disable iff (rst)
    op_valid && !is_qgt |=> !align_fault) // RULE14
    else $error("string compare raised alignment fault");
  a_qgt_lanes: assert property (@(posedge clk) disable iff (rst)
    dest_we |-> (dest[63:0] == '0 || dest[63:0] == '1) &&
    (dest[127:64] == '0 || dest[127:64] == '1)) // RULE15
    else $error("quadword lane not uniform");
  a_each_full_len: assert property (@(posedge clk) disable iff (rst)
    op_valid && explicit_len && !is_index && agg == AGG_EQUAL_EACH &&
    pol == 2'h0 && !sel && src_a == src_b && mag_a >= 32'h10 &&
    mag_b >= 32'h10 && !word_mode
    |=> vector_reg_zero[15:0] == 16'hFFFF) // RULE17
    else $error("oversized length not treated as full");

endmodule : pscu_top

// ### tb_pscu_top.sv
// Self-checking bench for pscu_top against a reference model.
// Assumes one-cycle result latency and inputs driven at the falling edge.
module tb_pscu_top
  import pscu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    bit           v;
    int           op;
    logic [127:0] val;
    bit           flt;
  } pscu_exp_s;
  localparam logic [31:0] FEATURE_WORD = 32'h00100000;
  localparam pscu_op_e OPS[5] = '{OP_EXPLICIT_LEN_COMPARE_INDEX,
    OP_EXPLICIT_LEN_COMPARE_MASK, OP_NULL_TERM_COMPARE_INDEX,
    OP_NULL_TERM_COMPARE_MASK, OP_QUADWORD_GREATER_COMPARE};
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             op_valid = 1'b0;
  pscu_op_e         op_kind = OP_EXPLICIT_LEN_COMPARE_INDEX;
  logic [7:0]       imm = 8'h00;
  logic [VEC_W-1:0] src_a = '0, src_b = '0, ra, rb;
  logic             src_b_is_mem = 1'b0;
  logic [3:0]       mem_addr_lo = 4'h0;
  logic [LEN_W-1:0] len_a = '0, len_b = '0, l1, l2;
  logic             res_valid, cnt_we, v0_we, dest_we, align_fault;
  logic [LEN_W-1:0] cnt, cnt_q;
  logic [VEC_W-1:0] v0, v0_q, dest;
  int               err_total = 0;
  int               check_count = 0;
  logic [31:0]      rnd = 32'h000166D3;
  pscu_exp_s        q[$];
  // Architected state the register file should hold, one write behind
  logic [LEN_W-1:0] arch_cnt;
  logic [VEC_W-1:0] arch_v0;
  bit               cnt_ok = 1'b0;
  bit               v0_ok = 1'b0;

  always #12.5 clk = ~clk;

  pscu_top dut_u (.clk(clk), .rst(rst), .op_valid(op_valid),
    .op_kind(op_kind), .imm(imm), .src_a(src_a), .src_b(src_b),
    .src_b_is_mem(src_b_is_mem), .mem_addr_lo(mem_addr_lo),
    .first_length_gpr(len_a), .second_length_gpr(len_b),
    .res_valid(res_valid), .count_gpr_we(cnt_we), .count_gpr(cnt),
    .vector_reg_zero_we(v0_we), .vector_reg_zero(v0),
    .dest_we(dest_we), .dest(dest), .align_fault(align_fault));
  pscu_regfile_model rf_u (.clk(clk), .cnt_we(cnt_we), .cnt_d(cnt),
    .v0_we(v0_we), .v0_d(v0), .cnt_q(cnt_q), .v0_q(v0_q));

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx

  function automatic int el(logic [127:0] v, int k, bit w, bit s);
    int x;
    x = w ? v[16*k +: 16] : v[8*k +: 8];
    if (s) x -= w ? (x > 32767 ? 65536 : 0) : (x > 127 ? 256 : 0);
    return x;
  endfunction : el

  function automatic int nlen(logic [127:0] v, bit w, int n);
    for (int k = 0; k < n; k++)
      if (el(v, k, w, 1'b0) == 0) return k;
    return n;
  endfunction : nlen

  function automatic int vlen(logic [31:0] l, int n);
    int m;
    m = $signed(l) < 0 ? -$signed(l) : $signed(l);
    return m > n ? n : m;
  endfunction : vlen

  function automatic logic [127:0] ref_out(int op, logic [7:0] c,
      logic [127:0] a, logic [127:0] b, logic [31:0] p1, logic [31:0] p2);
    int n, la, lb, r, i, j, x;
    bit w, s, t;
    logic [15:0] m;
    ref_out = '0;
    if (op == 6) begin
      for (i = 0; i < 2; i++)
        ref_out[64*i +: 64] = {64{$signed(a[64*i +: 64]) >
                                   $signed(b[64*i +: 64])}};
      return ref_out;
    end
    w = c[0];
    s = c[1];
    n = w ? 8 : 16;
    la = op[1] ? nlen(a, w, n) : vlen(p1, n);
    lb = op[1] ? nlen(b, w, n) : vlen(p2, n);
    m = '0;
    for (j = 0; j < n; j++) begin
      x = el(b, j, w, s);
      t = c[3:2] == 2'h3;
      case (c[3:2])
        2'h0: for (i = 0; i < la; i++)
            if (j < lb && el(a, i, w, s) == x) t = 1;
        2'h1: for (i = 0; i + 1 < la; i += 2)
            if (j < lb && el(a, i, w, s) <= x && x <= el(a, i + 1, w, s)) t = 1;
        2'h2: t = (j >= la && j >= lb) ||
                  (j < la && j < lb && el(a, j, w, s) == x);
        default: for (i = 0; i + j < n; i++)
            if (i < la && (i + j >= lb || el(a, i, w, s) != el(b, i + j, w, s)))
              t = 0;
      endcase
      m[j] = t ^ (c[4] && (!c[5] || j < lb));
    end
    if (!op[0]) begin
      r = n;
      for (j = 0; j < n; j++)
        if (m[j] && (c[6] || r == n)) r = j;
      return 128'(r);
    end
    if (!c[6]) return 128'(m);
    for (i = 0; i < 128; i++)
      ref_out[i] = m[w ? i / 16 : i / 8];
  endfunction : ref_out

  task automatic cmp1(input string nm, input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp1

  task automatic cmpv(input string nm, input logic [127:0] e,
                      input logic [127:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : cmpv

  task automatic chk(input pscu_exp_s e);
    bit ix, mk, qd;
    ix = e.v && e.op inside {0, 2};
    mk = e.v && e.op inside {1, 3};
    qd = e.v && e.op == 6;
    cmp1("res_valid", e.v, res_valid);
    cmp1("count_gpr_we", ix, cnt_we);
    cmp1("vector_reg_zero_we", mk, v0_we);
    cmp1("dest_we", qd && !e.flt, dest_we);
    cmp1("align_fault", qd && e.flt, align_fault);
    if (cnt_ok) cmpv("cnt_q", 128'(arch_cnt), 128'(cnt_q));
    if (v0_ok) cmpv("v0_q", arch_v0, v0_q);
    if (ix) cmpv("count_gpr", e.val, 128'(cnt));
    if (mk) cmpv("vector_reg_zero", e.val, v0);
    if (ix) begin
      arch_cnt = e.val[31:0];
      cnt_ok = 1'b1;
    end
    if (mk) begin
      arch_v0 = e.val;
      v0_ok = 1'b1;
    end
    if (qd) cmpv("dest", e.val, dest);
  endtask : chk

  task automatic step(input bit v, input bit r, input pscu_op_e op,
      input logic [7:0] c, input logic [127:0] a, input logic [127:0] b,
      input bit mem, input logic [3:0] lo);
    pscu_exp_s e;
    @(negedge clk);
    if (q.size() > 0) chk(q.pop_front());
    rst = r;
    op_valid = v;
    op_kind = op;
    imm = c;
    src_a = a;
    src_b = b;
    src_b_is_mem = mem;
    mem_addr_lo = lo;
    len_a = l1;
    len_b = l2;
    e.v = v && !r;
    e.op = op;
    e.val = ref_out(op, c, a, b, l1, l2);
    e.flt = mem && lo != 4'h0;
    q.push_back(e);
  endtask : step

  // Small alphabet with sign bit and nulls so that matches really occur
  task automatic gen();
    for (int i = 0; i < 16; i++) begin
      rnd = nx(rnd);
      ra[8*i +: 8] = {rnd[7], 4'h0, rnd[5:3]};
      rb[8*i +: 8] = {rnd[15], 4'h0, rnd[13:11]};
    end
    l1 = {27'h0, rnd[20:16]} - 32'h8;
    l2 = {27'h0, rnd[25:21]} - 32'h8;
    if (rnd[26]) rb = ra;
  endtask : gen

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    if (!FEATURE_WORD[20]) tally_and_finish();
    repeat (5) @(negedge clk);
    for (int k = 0; k < 640; k++) begin
      gen();
      step(rnd[2:0] != 3'h0, 1'b0, OPS[k % 5], {rnd[27], 7'(k / 5)},
           ra, rb, rnd[28], rnd[31:29] == 3'h0 ? 4'h0 : rnd[11:8]);
    end
    $display("test sweep done");
    step(1'b1, 1'b1, OPS[4], 8'h00, ra, rb, 1'b0, 4'h0);
    step(1'b0, 1'b0, OPS[4], 8'h00, ra, rb, 1'b0, 4'h0);
    cmpv("dest", '0, dest);
    step(1'b1, 1'b0, OPS[4], 8'h00, ra, ra, 1'b1, 4'h0);
    // Both lengths beyond sixteen, one negative: all elements valid
    l1 = 32'h00000014;
    l2 = 32'hFFFFFFEE;
    step(1'b1, 1'b0, OPS[1], 8'h08, ra, ra, 1'b0, 4'h0);
    step(1'b0, 1'b0, OPS[4], 8'h00, ra, rb, 1'b0, 4'h0);
    $display("test reset and equal lanes done");
    tally_and_finish();
  end

  // Sweep takes about 660 cycles; three times that means a hang
  initial begin
    #(2000 * 25);
    err_total++;
    tally_and_finish();
  end
endmodule : tb_pscu_top
